// File: common/rnc_consts.svh
// register offsets, field positions, reset values and timing for rnc
`ifndef RNC_CONSTS_SVH
`define RNC_CONSTS_SVH
`define RNC_OFF_BOR_CTL   6'h00
`define RNC_OFF_CAUSE     6'h01
`define RNC_OFF_SRST0     6'h02
`define RNC_OFF_SRST1     6'h03
`define RNC_OFF_SRST2     6'h04
`define RNC_OFF_APP_CTL   6'h05
`define RNC_OFF_INT_CTL   6'h06
`define RNC_OFF_OSC_CTL   6'h07
`define RNC_OFF_STATUS    6'h08
`define RNC_OFF_WD_BASE   6'h0C
`define RNC_WD_LOAD       2'h0
`define RNC_WD_CTL        2'h1
`define RNC_WD_ICLR       2'h2
`define RNC_WD_VALUE      2'h3
`define RNC_BIT_BOR_ACT   1
`define RNC_BIT_VECT      0
`define RNC_BIT_SYSREQ    2
`define RNC_BIT_NMI_SET   31
`define RNC_BIT_OSC_VER   0
`define RNC_BIT_WD_INTEN  0
`define RNC_BIT_WD_RESEN  1
`define RNC_C_EXT         0
`define RNC_C_POR         1
`define RNC_C_BOR         2
`define RNC_C_WD0         3
`define RNC_C_SW          4
`define RNC_C_WD1         5
`define RNC_C_OSC         16
`define RNC_S_NMI_PIN     0
`define RNC_S_OSC_NMI     1
`define RNC_S_BOR_INT     2
`define RNC_RST_BOR_CTL   32'h00000000
`define RNC_RST_CAUSE     32'h00000002
`define RNC_RST_WD_LOAD   32'hFFFFFFFF
`define RNC_CLK_KHZ       10000
`define RNC_BOR_HOLD_US   500
`define RNC_BOR_HOLD_CYC  ((`RNC_BOR_HOLD_US * `RNC_CLK_KHZ) / 1000)
`endif

// File: common/rnc_pkg.sv
// types shared by the reset and nmi control block
package rnc_pkg;
  typedef enum logic [1:0] {
    BOOT_SP,
    BOOT_PC,
    BOOT_INSN,
    BOOT_RUN
  } rnc_boot_t;
  typedef struct packed {
    logic core_n;
    logic sys_n;
    logic dbg_n;
  } rnc_rst_t;
endpackage

// File: hdl/rnc_ctrl.sv
// reset and non-maskable interrupt control with avalon-mm registers
`timescale 1ns/10ps
`default_nettype none
`include "rnc_consts.svh"
// Function
// - brown-out resets system when action select set, else raises interrupt
// - action select resets to interrupt response
// - brown-out during flash program or erase always resets system
// - brown-out flag held 500 us after release, blocking new interrupts, not resets
// - brown-out reset acts like pin reset, held while detector active
// - peripheral reset when its soft reset bit is set then cleared
// - soft reset bit layout matches peripheral clock gating layout
// - system reset request resets whole chip then restarts
// - core-only reset request resets core, not debug or peripherals
// - after reset core fetches stack pointer, counter, instruction, runs
// - two identical watchdogs, system clock and internal oscillator
// - watchdog interrupts on first time-out, resets on second
// - on first time-out watchdog reloads from load register
// - watchdog reset only when enabled and interrupt still uncleared
// - nmi from pin, oscillator verify error, or pend-set bit
// - nmi pin acts only when its locked alternate function enabled
// - nmi pin is active high
// - oscillator verify failure gives power-on reset then nmi
// - oscillator verification runs only while enable bit set
// - cause register records oscillator fail and brown-out
// - cause bits sticky, cleared by zero; power-on keeps only its bit, plus the oscillator bit on verify failure
// - peripheral soft reset resets debug port, not core
module rnc_ctrl #(
  parameter int P_BOR_HOLD_CYC = `RNC_BOR_HOLD_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_clk_en,
  input  wire logic [5:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_brownout_event,
  input  wire logic        i_flash_busy,
  input  wire logic        i_ext_rst_n,
  input  wire logic        i_port_b_pin_seven,
  input  wire logic        i_nmi_alt_en,
  input  wire logic        i_main_osc_fail,
  input  wire logic        i_precision_internal_osc_tick,
  output rnc_pkg::rnc_rst_t o_rst,
  output logic [95:0]      o_periph_rst,
  output logic             o_nmi,
  output logic             o_bor_irq,
  output logic [1:0]       o_wdt_irq,
  output rnc_pkg::rnc_boot_t o_boot_step
);

  // ==========================================================
  // input synchronisers
  logic [1:0] bor_s;
  logic [1:0] nmi_s;
  logic [1:0] osc_s;
  logic [1:0] ext_s;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bor_s <= 2'h0;
      nmi_s <= 2'h0;
      osc_s <= 2'h0;
      ext_s <= 2'h0;
    end else if (i_clk_en) begin
      bor_s <= {bor_s[0], i_brownout_event};
      nmi_s <= {nmi_s[0], i_port_b_pin_seven};
      osc_s <= {osc_s[0], i_main_osc_fail};
      ext_s <= {ext_s[0], ~i_ext_rst_n};
    end
  end
  wire bor_in = bor_s[1];
  wire osc_in = osc_s[1];
  wire ext_in = ext_s[1];
  wire nmi_in = nmi_s[1];

  // ==========================================================
  // bus decode
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction
  logic        wait_r;
  wire         acc    = (i_read | i_write) & ~wait_r;
  wire         wr     = i_write & acc;
  wire [31:0]  wd     = i_writedata;
  wire         w_bor  = wr & hit(i_address, `RNC_OFF_BOR_CTL);
  wire         w_cau  = wr & hit(i_address, `RNC_OFF_CAUSE);
  wire         w_app  = wr & hit(i_address, `RNC_OFF_APP_CTL);
  wire         w_int  = wr & hit(i_address, `RNC_OFF_INT_CTL);
  wire         w_osc  = wr & hit(i_address, `RNC_OFF_OSC_CTL);
  wire         w_sta  = wr & hit(i_address, `RNC_OFF_STATUS);

  // ==========================================================
  // control registers
  logic        bor_act_r;
  logic        osc_ver_r;
  logic        nmi_set_r;
  logic [31:0] cause_r;
  logic [31:0] cause_nxt;

  logic [31:0] srst_r [3];
  logic [31:0] srst_p [3];

  logic        bor_flag_r;
  logic        bor_int_r;
  logic        osc_nmi_r;
  logic        osc_p_r;
  logic [15:0] bor_cnt_r;
  logic        por_r;

  // ==========================================================
  // brown-out event and response
  wire bor_new   = bor_in & ~bor_flag_r;
  wire bor_rst   = bor_in & (bor_act_r | i_flash_busy);
  wire bor_irq_e = bor_new & ~bor_act_r & ~i_flash_busy;
  wire osc_fail  = osc_ver_r & osc_in & ~osc_p_r;
  wire clr_bor_int = w_sta & wd[`RNC_S_BOR_INT];
  wire clr_osc_nmi = w_sta & wd[`RNC_S_OSC_NMI];

  // ==========================================================
  // watchdogs
  logic [31:0] wd_load [2];
  logic [31:0] wd_cnt  [2];
  logic [1:0]  wd_ctl  [2];
  logic [1:0]  wd_irq;
  logic [1:0]  wd_rst;

  wire  [1:0]  wd_tick = {i_precision_internal_osc_tick, 1'b1};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_wd
      wire [5:0] base = `RNC_OFF_WD_BASE + 6'(4 * g);
      wire sel = wr & (i_address[5:2] == base[5:2]);
      wire w_ld = sel & (i_address[1:0] == `RNC_WD_LOAD);
      wire w_ct = sel & (i_address[1:0] == `RNC_WD_CTL);
      wire w_ic = sel & (i_address[1:0] == `RNC_WD_ICLR);
      wire run  = wd_ctl[g][`RNC_BIT_WD_INTEN] & wd_tick[g];
      wire zero = run & (wd_cnt[g] == 32'h00000000);

      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          wd_load[g] <= `RNC_RST_WD_LOAD;
          wd_cnt[g]  <= `RNC_RST_WD_LOAD;
          wd_ctl[g]  <= 2'h0;
          wd_irq[g]  <= 1'b0;
          wd_rst[g]  <= 1'b0;
        end else if (i_clk_en) begin
          wd_rst[g] <= zero & wd_irq[g]
                       & wd_ctl[g][`RNC_BIT_WD_RESEN];
          if (w_ld) begin
            wd_load[g] <= wd;
            wd_cnt[g]  <= wd;
          end else if (zero) begin
            wd_cnt[g] <= wd_load[g];
          end else if (run) begin
            wd_cnt[g] <= wd_cnt[g] - 32'h00000001;
          end
          if (w_ct) begin
            wd_ctl[g] <= wd[1:0] | wd_ctl[g];
          end
          if (zero) begin
            wd_irq[g] <= 1'b1;
          end else if (w_ic) begin
            wd_irq[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // peripheral soft reset, one pulse per set-then-cleared bit
  logic [95:0] prst_nxt;
  generate
    for (g = 0; g < 3; g++) begin : g_sr
      wire w_sr = wr & hit(i_address, `RNC_OFF_SRST0 + 6'(g));
      assign prst_nxt[32*g +: 32] = srst_p[g] & ~srst_r[g];
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          srst_r[g] <= 32'h00000000;
          srst_p[g] <= 32'h00000000;
        end else if (i_clk_en) begin
          srst_p[g] <= srst_r[g];
          if (w_sr) begin
            srst_r[g] <= wd;
          end
        end
      end
    end
  endgenerate
  wire prst_any = |prst_nxt;

  // ==========================================================
  // reset combining
  wire sysreq = w_app & wd[`RNC_BIT_SYSREQ];
  wire vect   = w_app & wd[`RNC_BIT_VECT];
  wire sys_req = bor_rst | ext_in | sysreq | (|wd_rst)
               | osc_fail | por_r;
  wire core_req = sys_req | vect;
  wire dbg_req  = sys_req | prst_any;

  // ==========================================================
  // cause register: writes of zero clear, events win
  wire [31:0] cause_set = ({31'h0, ext_in} << `RNC_C_EXT)
    | ({31'h0, bor_rst} << `RNC_C_BOR)
    | ({31'h0, wd_rst[0]} << `RNC_C_WD0)
    | ({31'h0, wd_rst[1]} << `RNC_C_WD1)
    | ({31'h0, sysreq} << `RNC_C_SW);

  wire [31:0] cause_keep = w_cau ? (cause_r & wd) : cause_r;
  wire [31:0] cause_por = (32'h1 << `RNC_C_POR)
    | (32'h1 << `RNC_C_OSC);
  assign cause_nxt = osc_fail ? cause_por
                   : (cause_keep | cause_set);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bor_act_r <= 1'(`RNC_RST_BOR_CTL >> `RNC_BIT_BOR_ACT);
      osc_ver_r <= 1'b0;
      nmi_set_r <= 1'b0;
      cause_r   <= `RNC_RST_CAUSE;
      osc_p_r   <= 1'b0;
      por_r     <= 1'b1;
    end else if (i_clk_en) begin
      por_r   <= 1'b0;
      osc_p_r <= osc_in;
      cause_r <= cause_nxt;
      if (w_bor) begin
        bor_act_r <= wd[`RNC_BIT_BOR_ACT];
      end
      if (w_osc) begin
        osc_ver_r <= wd[`RNC_BIT_OSC_VER];
      end
      if (w_int) begin
        nmi_set_r <= wd[`RNC_BIT_NMI_SET];
      end
    end
  end

  // ==========================================================
  // brown-out condition flag and hold counter
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bor_flag_r <= 1'b0;
      bor_cnt_r  <= 16'h0000;
      bor_int_r  <= 1'b0;
      osc_nmi_r  <= 1'b0;
    end else if (i_clk_en) begin
      if (bor_in) begin
        bor_flag_r <= 1'b1;
        bor_cnt_r  <= 16'(P_BOR_HOLD_CYC);
      end else if (bor_cnt_r != 16'h0000) begin
        bor_cnt_r <= bor_cnt_r - 16'h0001;
      end else begin
        bor_flag_r <= 1'b0;
      end
      if (bor_irq_e) begin
        bor_int_r <= 1'b1;
      end else if (clr_bor_int) begin
        bor_int_r <= 1'b0;
      end
      if (osc_fail) begin
        osc_nmi_r <= 1'b1;
      end else if (clr_osc_nmi) begin
        osc_nmi_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // reset outputs: asynchronous on power-up, released on the clock
  logic [1:0] core_q;
  logic [1:0] sys_q;
  logic [1:0] dbg_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      core_q <= 2'h0;
      sys_q  <= 2'h0;
      dbg_q  <= 2'h0;
    end else if (i_clk_en) begin
      core_q <= {core_q[0], ~core_req};
      sys_q  <= {sys_q[0], ~sys_req};
      dbg_q  <= {dbg_q[0], ~dbg_req};
    end
  end

  // ==========================================================
  // boot fetch sequence after core release
  rnc_pkg::rnc_boot_t boot_r;
  rnc_pkg::rnc_boot_t boot_nxt;

  always_comb begin
    boot_nxt = boot_r;
    case (boot_r)
      rnc_pkg::BOOT_SP:   boot_nxt = rnc_pkg::BOOT_PC;
      rnc_pkg::BOOT_PC:   boot_nxt = rnc_pkg::BOOT_INSN;
      rnc_pkg::BOOT_INSN: boot_nxt = rnc_pkg::BOOT_RUN;
      rnc_pkg::BOOT_RUN:  boot_nxt = rnc_pkg::BOOT_RUN;
      default:            boot_nxt = rnc_pkg::BOOT_SP;
    endcase
    if (!core_q[1]) begin
      boot_nxt = rnc_pkg::BOOT_SP;
    end
  end

  // ==========================================================
  // nmi and readback
  wire nmi_pin = nmi_in & i_nmi_alt_en;
  wire nmi_nxt = nmi_pin | osc_nmi_r | nmi_set_r;
  wire [31:0] status = ({31'h0, nmi_pin} << `RNC_S_NMI_PIN)
    | ({31'h0, osc_nmi_r} << `RNC_S_OSC_NMI)
    | ({31'h0, bor_int_r} << `RNC_S_BOR_INT);

  wire       wi   = i_address[4];
  wire       in_wd = i_address >= `RNC_OFF_WD_BASE
                   && i_address < `RNC_OFF_WD_BASE + 6'h08;

  wire [31:0] wd_rd =
    (i_address[1:0] == `RNC_WD_LOAD)  ? wd_load[wi] :
    (i_address[1:0] == `RNC_WD_CTL)   ? {30'h0, wd_ctl[wi]} :
    (i_address[1:0] == `RNC_WD_ICLR)  ? {31'h0, wd_irq[wi]} :
                                        wd_cnt[wi];

  wire [31:0] rd_mux =
    in_wd ? wd_rd :
    hit(i_address, `RNC_OFF_BOR_CTL) ? {30'h0, bor_act_r, 1'b0} :
    hit(i_address, `RNC_OFF_CAUSE)   ? cause_r :
    hit(i_address, `RNC_OFF_SRST0)   ? srst_r[0] :
    hit(i_address, `RNC_OFF_SRST1)   ? srst_r[1] :
    hit(i_address, `RNC_OFF_SRST2)   ? srst_r[2] :
    hit(i_address, `RNC_OFF_INT_CTL) ? {nmi_set_r, 31'h0} :
    hit(i_address, `RNC_OFF_OSC_CTL) ? {31'h0, osc_ver_r} :
    hit(i_address, `RNC_OFF_STATUS)  ? status :
                                       32'h00000000;

  // ==========================================================
  // registered outputs and bus handshake
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r       <= 1'b1;
      o_readdata   <= 32'h00000000;
      o_rst        <= '0;
      o_periph_rst <= '0;
      o_nmi        <= 1'b0;
      o_bor_irq    <= 1'b0;
      o_wdt_irq    <= 2'h0;
      o_boot_step  <= rnc_pkg::BOOT_SP;
      boot_r       <= rnc_pkg::BOOT_SP;
    end else if (i_clk_en) begin
      wait_r       <= ~((i_read | i_write) & wait_r);
      o_readdata   <= rd_mux;
      o_rst.core_n <= core_q[1];
      o_rst.sys_n  <= sys_q[1];
      o_rst.dbg_n  <= dbg_q[1];
      o_periph_rst <= prst_nxt | {96{~sys_q[1]}};
      o_nmi        <= nmi_nxt;
      o_bor_irq    <= bor_int_r;
      o_wdt_irq    <= wd_irq;
      boot_r       <= boot_nxt;
      o_boot_step  <= boot_nxt;
    end
  end
  assign o_waitrequest = wait_r;

endmodule
`default_nettype wire

// File: test/rnc_ctrl_asserts.sv
// port checks for the reset and nmi control block
`timescale 1ns/10ps
`default_nettype none
module rnc_ctrl_asserts (
  input wire logic               i_ref_clk,
  input wire logic               i_arst_n,
  input wire logic               i_brownout_event,
  input wire logic               i_flash_busy,
  input wire logic               i_ext_rst_n,
  input wire logic               i_port_b_pin_seven,
  input wire logic               i_nmi_alt_en,
  input wire rnc_pkg::rnc_rst_t  o_rst,
  input wire logic [95:0]        o_periph_rst,
  input wire logic               o_nmi,
  input wire rnc_pkg::rnc_boot_t o_boot_step
);
  // ==========
  // sequences
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_fetch;
    o_boot_step == rnc_pkg::BOOT_PC ##1 o_boot_step == rnc_pkg::BOOT_INSN
    ##1 o_boot_step == rnc_pkg::BOOT_RUN;
  endsequence
  sequence s_release;
    (!o_rst.sys_n) [*3] ##[1:3] o_rst.sys_n;
  endsequence
  // ==========
  // properties
  property p_release; $rose(i_arst_n) |-> s_release; endproperty
  a_release: assert property (p_release)
    else $error("system reset release off time");
  property p_boot; $rose(o_rst.core_n) |-> ##[0:1] s_fetch; endproperty
  a_boot: assert property (p_boot)
    else $error("bad fetch order after core release");
  property p_sys_core; !o_rst.sys_n |-> !o_rst.core_n; endproperty
  a_sys_core: assert property (p_sys_core)
    else $error("core runs during system reset");
  property p_sys_per; (!o_rst.sys_n) [*3] |-> &o_periph_rst; endproperty
  a_sys_per: assert property (p_sys_per)
    else $error("peripherals not reset by system reset");
  property p_vect; $fell(o_rst.core_n) && o_rst.sys_n |-> o_rst.dbg_n;
  endproperty
  a_vect: assert property (p_vect)
    else $error("debug reset by core-only reset");
  property p_soft; $fell(o_rst.dbg_n) && o_rst.sys_n |-> o_rst.core_n;
  endproperty
  a_soft: assert property (p_soft)
    else $error("core reset by peripheral reset");
  property p_pulse;
    o_rst.sys_n && $past(o_rst.sys_n) && (|o_periph_rst)
      |=> !o_rst.sys_n || o_periph_rst == 96'h0;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("peripheral reset pulse too long");
  property p_ext; (!i_ext_rst_n) [*8] |-> !o_rst.sys_n; endproperty
  a_ext: assert property (p_ext)
    else $error("pin reset not passed on");
  property p_bor; (i_brownout_event && i_flash_busy) [*8] |-> !o_rst.sys_n;
  endproperty
  a_bor: assert property (p_bor)
    else $error("no reset on brown-out during flash work");
  property p_nmi;
    (i_port_b_pin_seven && i_nmi_alt_en && o_rst.sys_n) [*5] |-> o_nmi;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi pin ignored");
endmodule
`default_nettype wire

// File: test/rnc_ctrl_tb.sv
// testbench for the reset and nmi control block
`timescale 1ns/10ps
`default_nettype none
`include "rnc_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  bad_count++; $display("wrong value t=%0t got %h exp %h", $time, g, e); \
  end end
module rnc_ctrl_tb;
  logic               i_ref_clk, i_arst_n, i_read, i_write, i_flash_busy;
  logic               i_brownout_event, i_ext_rst_n, i_port_b_pin_seven;
  logic               i_nmi_alt_en, i_main_osc_fail, i_precision_internal_osc_tick, clr;
  logic               o_waitrequest, o_nmi, o_bor_irq, boot_bad;
  logic [1:0]         o_wdt_irq;
  logic [5:0]         i_address;
  logic [7:0]         core_c, sys_c, dbg_c;
  logic [31:0]        i_writedata, o_readdata, q;
  logic [95:0]        o_periph_rst, hit;
  rnc_pkg::rnc_rst_t  o_rst;
  rnc_pkg::rnc_boot_t o_boot_step;
  int                 bad_count, samples_checked, cyc, b, k;
  rnc_ctrl #(.P_BOR_HOLD_CYC(8)) dut (.i_ref_clk, .i_arst_n, .i_clk_en(1'b1),
    .i_address, .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest,
    .i_brownout_event, .i_flash_busy, .i_ext_rst_n, .i_port_b_pin_seven,
    .i_nmi_alt_en, .i_main_osc_fail, .i_precision_internal_osc_tick, .o_rst, .o_periph_rst,
    .o_nmi, .o_bor_irq, .o_wdt_irq, .o_boot_step);
  rnc_reset_sink far (.i_clk(i_ref_clk), .i_clr(clr), .i_rst(o_rst),
    .i_periph_rst(o_periph_rst), .i_boot_step(o_boot_step),
    .o_core_cnt(core_c), .o_sys_cnt(sys_c), .o_dbg_cnt(dbg_c),
    .o_periph_hit(hit), .o_boot_bad(boot_bad));
  // ==========
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    i_address   <= a;
    i_writedata <= d;
    i_write     <= wr;
    i_read      <= !wr;
    @(posedge i_ref_clk);
    while (o_waitrequest !== 1'b0) @(posedge i_ref_clk);
    q = o_readdata;
    i_write <= 1'b0;
    i_read  <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic pulse_bor(input int h, input int w);
    i_brownout_event <= 1'b1;
    tick(h);
    i_brownout_event <= 1'b0;
    tick(w);
  endtask
  task automatic zap;
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(1);
  endtask
  function automatic logic [95:0] soft_mask(input int r, input int s);
    return 96'h1 << (32 * r + s);
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========
  // clock, ticks and timeout
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    i_precision_internal_osc_tick <= ($urandom % 4) == 0;
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  // ==========
  // scenarios
  initial begin
    b = $urandom(62480);
    {i_arst_n, i_read, i_write, i_brownout_event, i_flash_busy} = 5'h00;
    {i_port_b_pin_seven, i_nmi_alt_en, i_main_osc_fail, i_precision_internal_osc_tick} = 4'h0;
    {i_ext_rst_n, clr, i_address, i_writedata} = {2'h3, 6'h00, 32'h0};
    tick(5);
    i_arst_n <= 1'b1;
    tick(8);
    clr <= 1'b0;
    bus(1'b0, `RNC_OFF_BOR_CTL, 32'h0);
    `CHK(q, `RNC_RST_BOR_CTL)
    bus(1'b0, `RNC_OFF_CAUSE, 32'h0);
    `CHK(q, `RNC_RST_CAUSE)
    bus(1'b1, 6'h3F, 32'hFFFFFFFF);
    bus(1'b0, 6'h3F, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, `RNC_OFF_BOR_CTL, 32'h0);
    `CHK(q, `RNC_RST_BOR_CTL)
    bus(1'b1, `RNC_OFF_CAUSE, 32'h0);
    bus(1'b0, `RNC_OFF_CAUSE, 32'h0);
    `CHK(q, 32'h0)
    i_brownout_event <= 1'b1;
    tick(8);
    `CHK({o_bor_irq, sys_c}, 9'h100)
    i_brownout_event <= 1'b0;
    bus(1'b1, `RNC_OFF_STATUS, 32'h1 << `RNC_S_BOR_INT);
    pulse_bor(2, 4);
    `CHK(o_bor_irq, 1'b0)
    tick(20);
    pulse_bor(3, 4);
    `CHK(o_bor_irq, 1'b1)
    bus(1'b1, `RNC_OFF_STATUS, 32'h1 << `RNC_S_BOR_INT);
    tick(20);
    i_flash_busy <= 1'b1;
    pulse_bor(12, 0);
    `CHK(o_rst.sys_n, 1'b0)
    i_flash_busy <= 1'b0;
    tick(20);
    `CHK(sys_c, 8'h01)
    bus(1'b0, `RNC_OFF_CAUSE, 32'h0);
    `CHK(q[`RNC_C_BOR], 1'b1)
    bus(1'b1, `RNC_OFF_BOR_CTL, 32'h1 << `RNC_BIT_BOR_ACT);
    tick(10);
    pulse_bor(8, 20);
    `CHK(sys_c, 8'h02)
    i_ext_rst_n <= 1'b0;
    tick(8);
    i_ext_rst_n <= 1'b1;
    tick(10);
    `CHK(sys_c, 8'h03)
    bus(1'b0, `RNC_OFF_CAUSE, 32'h0);
    `CHK({q[`RNC_C_BOR], q[`RNC_C_EXT]}, 2'b11)
    for (k = 0; k < 3; k++) begin
      b = (k == 2) ? 31 : $urandom % 32;
      zap();
      bus(1'b1, 6'(`RNC_OFF_SRST0 + k), 32'h1 << b);
      tick(4);
      `CHK(hit, 96'h0)
      bus(1'b1, 6'(`RNC_OFF_SRST0 + k), 32'h0);
      tick(4);
      `CHK(hit, soft_mask(k, b))
      `CHK({core_c, dbg_c}, 16'h0001)
    end
    zap();
    bus(1'b1, `RNC_OFF_APP_CTL, 32'h1 << `RNC_BIT_VECT);
    tick(10);
    `CHK({core_c, sys_c, dbg_c, hit}, {24'h010000, 96'h0})
    zap();
    bus(1'b1, `RNC_OFF_APP_CTL, 32'h1 << `RNC_BIT_SYSREQ);
    tick(10);
    `CHK({core_c, sys_c, dbg_c, hit}, {24'h010101, {96{1'b1}}})
    `CHK(boot_bad, 1'b0)
    i_port_b_pin_seven <= 1'b1;
    tick(6);
    `CHK(o_nmi, 1'b0)
    i_nmi_alt_en <= 1'b1;
    tick(6);
    `CHK(o_nmi, 1'b1)
    bus(1'b0, `RNC_OFF_STATUS, 32'h0);
    `CHK(q[`RNC_S_NMI_PIN], 1'b1)
    i_port_b_pin_seven <= 1'b0;
    tick(6);
    `CHK(o_nmi, 1'b0)
    bus(1'b1, `RNC_OFF_INT_CTL, 32'h1 << `RNC_BIT_NMI_SET);
    tick(3);
    `CHK(o_nmi, 1'b1)
    bus(1'b1, `RNC_OFF_INT_CTL, 32'h0);
    zap();
    i_main_osc_fail <= 1'b1;
    tick(8);
    i_main_osc_fail <= 1'b0;
    tick(4);
    `CHK({sys_c, o_nmi}, 9'h000)
    bus(1'b1, `RNC_OFF_OSC_CTL, 32'h1 << `RNC_BIT_OSC_VER);
    i_main_osc_fail <= 1'b1;
    tick(4);
    i_main_osc_fail <= 1'b0;
    tick(12);
    `CHK({sys_c, o_nmi}, 9'h003)
    bus(1'b0, `RNC_OFF_CAUSE, 32'h0);
    `CHK(q, 32'h00010002)
    bus(1'b1, `RNC_OFF_STATUS, 32'h1 << `RNC_S_OSC_NMI);
    zap();
    bus(1'b1, 6'(`RNC_OFF_WD_BASE + 6'h4 + `RNC_WD_LOAD), 32'h8);
    tick(4);
    bus(1'b1, 6'(`RNC_OFF_WD_BASE + 6'h4 + `RNC_WD_CTL), 32'h1);
    tick(120);
    `CHK({o_wdt_irq[1], sys_c}, 9'h100)
    bus(1'b1, 6'(`RNC_OFF_WD_BASE + `RNC_WD_LOAD), 32'h1E);
    bus(1'b1, 6'(`RNC_OFF_WD_BASE + `RNC_WD_CTL), 32'h3);
    tick(20);
    `CHK(o_wdt_irq[0], 1'b0)
    tick(20);
    `CHK(o_wdt_irq[0], 1'b1)
    tick(10);
    `CHK(sys_c, 8'h00)
    tick(30);
    `CHK(sys_c, 8'h01)
    bus(1'b1, 6'(`RNC_OFF_WD_BASE + `RNC_WD_ICLR), 32'h0);
    tick(2);
    `CHK(o_wdt_irq[0], 1'b0)
    tick(30);
    `CHK(sys_c, 8'h01)
    bus(1'b0, 6'(`RNC_OFF_WD_BASE + `RNC_WD_LOAD), 32'h0);
    `CHK(q, 32'h1E)
    results();
  end
endmodule
bind rnc_ctrl rnc_ctrl_asserts u_chk (.i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n), .i_brownout_event(i_brownout_event),
  .i_flash_busy(i_flash_busy), .i_ext_rst_n(i_ext_rst_n),
  .i_port_b_pin_seven(i_port_b_pin_seven), .i_nmi_alt_en(i_nmi_alt_en),
  .o_rst(o_rst), .o_periph_rst(o_periph_rst), .o_nmi(o_nmi),
  .o_boot_step(o_boot_step));
`default_nettype wire

// File: test/rnc_reset_sink.sv
// model of the core and peripherals that receive the resets
`timescale 1ns/10ps
`default_nettype none
module rnc_reset_sink (
  input  wire logic               i_clk,
  input  wire logic               i_clr,
  input  wire rnc_pkg::rnc_rst_t  i_rst,
  input  wire logic [95:0]        i_periph_rst,
  input  wire rnc_pkg::rnc_boot_t i_boot_step,
  output logic [7:0]              o_core_cnt,
  output logic [7:0]              o_sys_cnt,
  output logic [7:0]              o_dbg_cnt,
  output logic [95:0]             o_periph_hit,
  output logic                    o_boot_bad
);
  // ==========
  // count reset entries and follow the fetch order
  rnc_pkg::rnc_rst_t  prev_r;
  rnc_pkg::rnc_boot_t step_r;
  rnc_pkg::rnc_boot_t step_nxt;
  assign step_nxt = rnc_pkg::rnc_boot_t'(step_r + 2'h1);
  always_ff @(posedge i_clk) begin
    prev_r <= i_rst;
    step_r <= i_boot_step;
    if (i_clr) begin
      o_core_cnt   <= 8'h00;
      o_sys_cnt    <= 8'h00;
      o_dbg_cnt    <= 8'h00;
      o_periph_hit <= 96'h0;
      o_boot_bad   <= 1'b0;
    end else begin
      if (prev_r.core_n && !i_rst.core_n) o_core_cnt <= o_core_cnt + 8'h01;
      if (prev_r.sys_n && !i_rst.sys_n) o_sys_cnt <= o_sys_cnt + 8'h01;
      if (prev_r.dbg_n && !i_rst.dbg_n) o_dbg_cnt <= o_dbg_cnt + 8'h01;
      o_periph_hit <= o_periph_hit | i_periph_rst;
      if (prev_r.core_n && i_rst.core_n && i_boot_step != step_r &&
          i_boot_step != step_nxt) o_boot_bad <= 1'b1;
    end
  end
endmodule
`default_nettype wire
